// ### rtl/ninth_bit_wait_unit.sv
// Top: APB registers, wait-stall control and registered ninth-bit results
`default_nettype none
module ninth_bit_wait_unit #(
	parameter int WAIT_CNT_W = 16
) (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [ninth_bit_pkg::ADDR_W-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [3:0] i_pstrb,
	output logic o_pready,
	output logic [31:0] o_prdata,
	output logic o_pslverr,
	input wire logic i_wait_req,
	input wire logic i_halt,
	input wire logic i_hold,
	input wire logic i_op_valid,
	input wire ninth_bit_pkg::op_t i_op,
	input wire ninth_bit_pkg::opnd_t i_opnd,
	output logic o_stall,
	output logic o_ram_xfer,
	output logic o_periph_run,
	output logic o_cont_en,
	output logic o_flag,
	output ninth_bit_pkg::res_t o_res
);
	// ----------------------------------------
	// Elaboration checks
	// ----------------------------------------
	if (WAIT_CNT_W < 1 || WAIT_CNT_W > 32)
	begin : g_bad_width
		$error("WAIT_CNT_W must lie between 1 and 32");
	end

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic cont_en;
		logic flag;
		logic stall;
		logic xfer;
		logic periph_run;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic [WAIT_CNT_W-1:0] wait_cnt;
		ninth_bit_pkg::res_t res;
	} state_t;

	state_t st_r;
	state_t st_nxt;
	ninth_bit_pkg::res_t alu_res;
	logic accept;
	logic take;
	logic setup;
	logic access;
	logic hit_ctrl;
	logic hit_psw;
	logic hit_cnt;

	ninth_bit_alu u_alu (
		.i_op(i_op),
		.i_opnd(i_opnd),
		.i_flag(st_r.flag),
		.o_res(alu_res)
	);

	// ----------------------------------------
	// Wait stall and execution gating
	// ----------------------------------------
	// A stall cycle blocks the next accept, so two never follow
	assign accept = st_r.cont_en & i_wait_req & ~i_halt & ~i_hold & ~st_r.stall;
	// Instructions are held off during the stalled cycle only
	assign take = i_op_valid & ~st_r.stall;

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	assign setup = i_psel & ~i_penable;
	assign access = i_psel & i_penable & st_r.pready;
	assign hit_ctrl = (i_paddr == ninth_bit_pkg::OFS_SER_CTRL);
	assign hit_psw = (i_paddr == ninth_bit_pkg::OFS_PSW);
	assign hit_cnt = (i_paddr == ninth_bit_pkg::OFS_WAIT_CNT);

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.stall = accept;
		st_nxt.xfer = accept;
		// Peripheral clocking never depends on the stall
		st_nxt.periph_run = 1'b1;
		if (accept)
			st_nxt.wait_cnt = st_r.wait_cnt + {{(WAIT_CNT_W-1){1'b0}}, 1'b1};
		st_nxt.pready = 1'b0;
		st_nxt.pslverr = 1'b0;
		if (setup)
		begin
			st_nxt.pready = 1'b1;
			st_nxt.pslverr = ~(hit_ctrl | hit_psw | hit_cnt);
			st_nxt.prdata = ninth_bit_pkg::RD_ZERO;
			if (hit_ctrl)
				st_nxt.prdata[ninth_bit_pkg::CTE_BIT] = st_r.cont_en;
			if (hit_psw)
				st_nxt.prdata[ninth_bit_pkg::FLAG_BIT] = st_r.flag;
			if (hit_cnt)
				st_nxt.prdata[WAIT_CNT_W-1:0] = st_r.wait_cnt;
		end
		if (access & i_pwrite & i_pstrb[0])
		begin
			if (hit_ctrl)
				st_nxt.cont_en = i_pwdata[ninth_bit_pkg::CTE_BIT];
			if (hit_psw)
				st_nxt.flag = i_pwdata[ninth_bit_pkg::FLAG_BIT];
		end
		// A stall in the clearing cycle still counts, so no wait is lost
		if (access & i_pwrite & hit_cnt)
			st_nxt.wait_cnt = {{(WAIT_CNT_W-1){1'b0}}, accept};
		// Instruction update wins over a software write in the same cycle
		st_nxt.res.valid = 1'b0;
		if (take)
		begin
			st_nxt.res = alu_res;
			st_nxt.flag = alu_res.flag;
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
		begin
			st_r <= '0;
			st_r.cont_en <= ninth_bit_pkg::RST_CTE;
			st_r.flag <= ninth_bit_pkg::RST_FLAG;
		end
		else
			st_r <= st_nxt;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign o_pready = st_r.pready;
	assign o_prdata = st_r.prdata;
	assign o_pslverr = st_r.pslverr;
	assign o_stall = st_r.stall;
	assign o_ram_xfer = st_r.xfer;
	assign o_periph_run = st_r.periph_run;
	assign o_cont_en = st_r.cont_en;
	assign o_flag = st_r.flag;
	assign o_res = st_r.res;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	sequence s_request;
		st_r.cont_en && i_wait_req && !i_halt && !i_hold && !st_r.stall;
	endsequence
	sequence s_stall_cycle;
		o_stall && o_ram_xfer;
	endsequence

	AST_REQ_GIVES_STALL: assert property (@(posedge i_mclk) disable iff (i_rst)
		s_request |=> s_stall_cycle ##1 !o_stall)
		else $error("wait request did not give exactly one stall cycle");
	AST_STALL_HAS_CAUSE: assert property (@(posedge i_mclk) disable iff (i_rst)
		$rose(o_stall) |-> $past(i_wait_req) && $past(o_cont_en))
		else $error("stall without a wait request");
	AST_NO_EXEC_IN_STALL: assert property (@(posedge i_mclk) disable iff (i_rst)
		o_stall && i_op_valid |=> !o_res.valid)
		else $error("instruction executed during stall");
	AST_PERIPH_RUNS: assert property (@(posedge i_mclk) disable iff (i_rst)
		##1 o_stall |-> o_periph_run)
		else $error("peripherals halted by stall");
	AST_NO_BACK_TO_BACK: assert property (@(posedge i_mclk) disable iff (i_rst)
		o_stall |=> !o_stall)
		else $error("two stall cycles in a row");
	AST_NO_WAIT_HALT: assert property (@(posedge i_mclk) disable iff (i_rst)
		(i_halt || i_hold) |=> !o_stall)
		else $error("stall in HALT or HOLD");
	AST_WIDE_SETS_B8: assert property (@(posedge i_mclk) disable iff (i_rst)
		take && i_op == ninth_bit_pkg::OP_WIDE_MULDIV |=> o_res.lo_b8 && o_res.hi_b8)
		else $error("wide result ninth bit not one");
	AST_POP_PSW_FLAG: assert property (@(posedge i_mclk) disable iff (i_rst)
		take && i_op == ninth_bit_pkg::OP_POP && i_opnd.psw_dest
		|=> o_flag == $past(i_opnd.lo[ninth_bit_pkg::FLAG_BIT]))
		else $error("status pop flag not from bit 1");
	AST_MISSING_B8_ONE: assert property (@(posedge i_mclk) disable iff (i_rst)
		take && i_op == ninth_bit_pkg::OP_LOAD && i_opnd.no_b8 |=> o_flag)
		else $error("missing ninth bit not read as one");
	AST_DBZ_TEST: assert property (@(posedge i_mclk) disable iff (i_rst)
		take && i_op == ninth_bit_pkg::OP_DBZ
		|=> o_res.branch == ($past(i_opnd.lo) == ninth_bit_pkg::BYTE_ONE)
		&& o_flag == o_res.lo_b8)
		else $error("decrement-branch-zero result wrong");
	AST_INC_NINE: assert property (@(posedge i_mclk) disable iff (i_rst)
		take && i_op == ninth_bit_pkg::OP_INC && !i_opnd.no_b8
		|=> {o_res.lo_b8, o_res.lo} == 9'($past({i_opnd.lo_b8, i_opnd.lo}) + 9'h001))
		else $error("byte increment not over nine bits");
	AST_WORD_INCREMENT_CARRY: assert property (@(posedge i_mclk) disable iff (i_rst)
		take && i_op == ninth_bit_pkg::OP_WORD_INCREMENT
		|=> o_res.lo_b8 == ($past(i_opnd.lo) == 8'hff))
		else $error("word increment low carry wrong");
	AST_WORD_POP_PSW_FLAG: assert property (@(posedge i_mclk) disable iff (i_rst)
		take && i_op == ninth_bit_pkg::OP_WORD_POP && i_opnd.psw_dest
		|=> o_flag == $past(i_opnd.hi[ninth_bit_pkg::FLAG_BIT]))
		else $error("status word pop flag not from bit 1");
	AST_WORD_DECREMENT_BORROW: assert property (@(posedge i_mclk) disable iff (i_rst)
		take && i_op == ninth_bit_pkg::OP_WORD_DECREMENT
		|=> o_res.lo_b8 == ($past(i_opnd.lo) != 8'h00))
		else $error("word decrement low borrow wrong");
	AST_STORE_FLAG: assert property (@(posedge i_mclk) disable iff (i_rst)
		take && i_op == ninth_bit_pkg::OP_STORE |=> o_res.lo_b8 == $past(o_flag))
		else $error("store ninth bit not from flag");
endmodule // ninth_bit_wait_unit
`default_nettype wire

// ### rtl/ninth_bit_pkg.sv
// Shared constants and types for the ninth-bit and wait-stall unit
// Overview of operation
// - Continuous serial transfer requests one wait cycle
// - Wait stalls execution one cycle, transfers data
// - Peripherals keep running during a wait cycle
// - Never two wait cycles back to back
// - No wait cycles in HALT or HOLD
// - Locations carry a ninth bit unless marked no_b8
// - Missing ninth bit reads as one
// - Wide multiply/divide results get ninth bit one
// - Byte pop into status word uses bit 1
// - Word pop into status word uses bit 1
// - Decrement-branch: 9-bit decrement, 8-bit test, flag copy
// - Word increment 17 bits, low ninth gets carry
// - Word decrement 17 bits, low ninth gets inverted borrow
`default_nettype none
package ninth_bit_pkg;
	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam int ADDR_W = 12;
	localparam logic [11:0] OFS_SER_CTRL = 12'h000;
	localparam logic [11:0] OFS_PSW = 12'h004;
	localparam logic [11:0] OFS_WAIT_CNT = 12'h008;
	localparam int CTE_BIT = 4;
	localparam int FLAG_BIT = 1;
	localparam logic RST_CTE = 1'h0;
	localparam logic RST_FLAG = 1'h0;
	localparam logic [31:0] RD_ZERO = 32'h0000_0000;
	localparam logic [7:0] BYTE_ONE = 8'h01;
	localparam logic [8:0] NINE_ONE = 9'h001;
	localparam logic [16:0] SEVENTEEN_ONE = 17'h0_0001;
	// ----------------------------------------
	// Instruction classes
	// ----------------------------------------
	typedef enum logic [4:0] {
		OP_NONE = 5'h00, OP_LOAD = 5'h01, OP_LOADW = 5'h02, OP_STORE = 5'h03,
		OP_STOREW = 5'h04, OP_MOV = 5'h05, OP_PUSH_IMM = 5'h06, OP_PUSH = 5'h07,
		OP_PUSHW = 5'h08, OP_PUSH_P = 5'h09, OP_PUSH_BA = 5'h0a, OP_POP = 5'h0b,
		OP_WORD_POP = 5'h0c, OP_POP_P = 5'h0d, OP_POP_BA = 5'h0e, OP_XCH = 5'h0f,
		OP_XCHW = 5'h10, OP_INC = 5'h11, OP_WORD_INCREMENT = 5'h12, OP_DEC = 5'h13,
		OP_WORD_DECREMENT = 5'h14, OP_DECREMENT_BRANCH_NONZERO = 5'h15, OP_DBZ = 5'h16, OP_BITOP = 5'h17,
		OP_WIDE_MULDIV = 5'h18
	} op_t;
	typedef struct packed {
		logic [7:0] lo;
		logic lo_b8;
		logic [7:0] hi;
		logic hi_b8;
		logic no_b8;
		logic psw_dest;
	} opnd_t;
	typedef struct packed {
		logic valid;
		logic [7:0] lo;
		logic lo_b8;
		logic [7:0] hi;
		logic hi_b8;
		logic flag;
		logic branch;
	} res_t;
endpackage
`default_nettype wire

// ### rtl/ninth_bit_alu.sv
// Combinational ninth-bit and flag update per instruction class
`default_nettype none
module ninth_bit_alu (
	input wire ninth_bit_pkg::op_t i_op,
	input wire ninth_bit_pkg::opnd_t i_opnd,
	input wire logic i_flag,
	output ninth_bit_pkg::res_t o_res
);
	logic lo8;
	logic hi8;
	logic [8:0] b9;
	logic [16:0] w17;
	// Plain 8-bit sources have no bit 8
	assign lo8 = i_opnd.no_b8 | i_opnd.lo_b8;
	assign hi8 = i_opnd.no_b8 | i_opnd.hi_b8;

	always_comb
	begin
		b9 = 9'h000;
		w17 = 17'h0_0000;
		o_res = '0;
		o_res.valid = 1'b1;
		o_res.lo = i_opnd.lo;
		o_res.hi = i_opnd.hi;
		o_res.lo_b8 = lo8;
		o_res.hi_b8 = hi8;
		o_res.flag = i_flag;
		unique case (i_op)
			ninth_bit_pkg::OP_LOAD: o_res.flag = lo8;
			ninth_bit_pkg::OP_LOADW, ninth_bit_pkg::OP_POP_BA: o_res.flag = hi8;
			ninth_bit_pkg::OP_STORE, ninth_bit_pkg::OP_MOV, ninth_bit_pkg::OP_PUSH_IMM,
			ninth_bit_pkg::OP_PUSH_P: o_res.lo_b8 = i_flag;
			ninth_bit_pkg::OP_STOREW, ninth_bit_pkg::OP_PUSH_BA:
			begin
				o_res.lo_b8 = i_flag;
				o_res.hi_b8 = i_flag;
			end
			ninth_bit_pkg::OP_PUSH: o_res.flag = lo8;
			ninth_bit_pkg::OP_PUSHW: o_res.flag = hi8;
			ninth_bit_pkg::OP_POP:
				o_res.flag = i_opnd.psw_dest ? i_opnd.lo[ninth_bit_pkg::FLAG_BIT] : lo8;
			ninth_bit_pkg::OP_WORD_POP:
				o_res.flag = i_opnd.psw_dest ? i_opnd.hi[ninth_bit_pkg::FLAG_BIT] : hi8;
			ninth_bit_pkg::OP_POP_P: o_res.flag = i_opnd.lo[ninth_bit_pkg::FLAG_BIT];
			ninth_bit_pkg::OP_XCH:
			begin
				o_res.lo_b8 = i_flag;
				o_res.flag = lo8;
			end
			ninth_bit_pkg::OP_XCHW:
			begin
				o_res.lo_b8 = i_flag;
				o_res.hi_b8 = i_flag;
				o_res.flag = hi8;
			end
			ninth_bit_pkg::OP_INC, ninth_bit_pkg::OP_DEC, ninth_bit_pkg::OP_DECREMENT_BRANCH_NONZERO,
			ninth_bit_pkg::OP_DBZ:
			begin
				b9 = (i_op == ninth_bit_pkg::OP_INC) ? ({lo8, i_opnd.lo} + ninth_bit_pkg::NINE_ONE)
					: ({lo8, i_opnd.lo} - ninth_bit_pkg::NINE_ONE);
				{o_res.lo_b8, o_res.lo} = b9;
				o_res.flag = b9[8];
				if (i_op == ninth_bit_pkg::OP_DBZ)
					o_res.branch = (b9[7:0] == 8'h00);
				else if (i_op == ninth_bit_pkg::OP_DECREMENT_BRANCH_NONZERO)
					o_res.branch = (b9[7:0] != 8'h00);
			end
			ninth_bit_pkg::OP_WORD_INCREMENT:
			begin
				w17 = {hi8, i_opnd.hi, i_opnd.lo} + ninth_bit_pkg::SEVENTEEN_ONE;
				{o_res.hi_b8, o_res.hi, o_res.lo} = w17;
				o_res.lo_b8 = (i_opnd.lo == 8'hff);
				o_res.flag = w17[16];
			end
			ninth_bit_pkg::OP_WORD_DECREMENT:
			begin
				w17 = {hi8, i_opnd.hi, i_opnd.lo} - ninth_bit_pkg::SEVENTEEN_ONE;
				{o_res.hi_b8, o_res.hi, o_res.lo} = w17;
				o_res.lo_b8 = (i_opnd.lo != 8'h00);
				o_res.flag = w17[16];
			end
			ninth_bit_pkg::OP_WIDE_MULDIV:
			begin
				o_res.lo_b8 = 1'b1;
				o_res.hi_b8 = 1'b1;
			end
			// Bit ops and the no-op leave everything as it was; other unlisted classes clear valid
			ninth_bit_pkg::OP_BITOP, ninth_bit_pkg::OP_NONE: o_res.lo_b8 = lo8;
			default: o_res.valid = 1'b0;
		endcase
	end
endmodule // ninth_bit_alu
`default_nettype wire

// ### tb/serial_req_model.sv
// Serial port stand-in that asks for one wait cycle per byte
`default_nettype none
module serial_req_model (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_go,
	input wire logic [3:0] i_gap,
	input wire logic i_ram_xfer,
	output logic o_wait_req,
	output logic [7:0] o_bytes
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] gap_r;
	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_wait_req <= 1'b0;
			o_bytes <= 8'h00;
			gap_r <= 4'h0;
		end
		else if (o_wait_req && i_ram_xfer)
		begin
			// Held until granted, so a blocked request is never lost
			o_wait_req <= 1'b0;
			o_bytes <= o_bytes + 8'h01;
			gap_r <= i_gap;
		end
		else if (gap_r != 4'h0)
			gap_r <= gap_r - 4'h1;
		else if (i_go && !o_wait_req)
			o_wait_req <= 1'b1;
	end
endmodule // serial_req_model
`default_nettype wire

// ### tb/tb_top.sv
// Bench for the ninth-bit and wait-stall unit
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_mclk = 1'b0;
	logic i_rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic pready, pslverr, wait_req, stall, ram_xfer, periph_run, cont_en, flag;
	logic [31:0] prdata;
	logic halt = 1'b0;
	logic hold = 1'b0;
	logic op_valid = 1'b0;
	logic go = 1'b0;
	logic stall_d = 1'b0;
	logic [3:0] gap = 4'h0;
	logic [7:0] bytes;
	ninth_bit_pkg::op_t op = ninth_bit_pkg::OP_NONE;
	ninth_bit_pkg::opnd_t opnd = '0;
	ninth_bit_pkg::res_t res;
	int failures = 0;
	int compares = 0;
	int stalls = 0;
	always #2.5 i_mclk = ~i_mclk;
	ninth_bit_wait_unit dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
		.i_pstrb(4'hf), .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
		.i_wait_req(wait_req), .i_halt(halt), .i_hold(hold), .i_op_valid(op_valid),
		.i_op(op), .i_opnd(opnd), .o_stall(stall), .o_ram_xfer(ram_xfer),
		.o_periph_run(periph_run), .o_cont_en(cont_en), .o_flag(flag), .o_res(res));
	serial_req_model partner (.i_mclk(i_mclk), .i_rst(i_rst), .i_go(go), .i_gap(gap),
		.i_ram_xfer(ram_xfer), .o_wait_req(wait_req), .o_bytes(bytes));
	// ----------------------------------------
	// Checking helpers
	// ----------------------------------------
	task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e)
		begin
			failures++;
			$display("wrong value %s expected %h seen %h", w, e, g);
		end
	endtask
	task automatic chk1(input string w, input logic e, input logic g);
		compares++;
		if (g !== e)
		begin
			failures++;
			$display("wrong value %s expected %b seen %b", w, e, g);
		end
	endtask
	task automatic end_of_test;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge i_mclk)
	begin
		stall_d <= stall & ~i_rst;
		if (!i_rst && stall === 1'b1)
		begin
			stalls <= stalls + 1;
			chk1("ram_xfer", 1'b1, ram_xfer);
			chk1("periph_run", 1'b1, periph_run);
			chk1("back to back stall", 1'b0, stall_d);
		end
	end
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge i_mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge i_mclk);
		penable <= 1'b1;
		@(posedge i_mclk);
		while (pready !== 1'b1)
			@(posedge i_mclk);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 32'h0, q, e);
		chk("prdata", x, q);
		chk1("pslverr", xe, e);
	endtask
	task automatic wait_bytes(input logic [7:0] n);
		while (bytes < n)
			@(posedge i_mclk);
	endtask
	// Mask c: lo ninth, lo, hi ninth, hi, branch
	task automatic t_op(input logic f, input ninth_bit_pkg::op_t o, input logic [8:0] l,
		input logic [8:0] h, input logic [1:0] m, input logic [8:0] el, input logic [8:0] eh,
		input logic ef, input logic eb, input logic [4:0] c);
		wr(ninth_bit_pkg::OFS_PSW, {30'h0, f, 1'b0});
		@(posedge i_mclk);
		op_valid <= 1'b1;
		op <= o;
		opnd <= {l[7:0], l[8], h[7:0], h[8], m};
		@(posedge i_mclk);
		while (stall !== 1'b0)
			@(posedge i_mclk);
		op_valid <= 1'b0;
		@(posedge i_mclk);
		chk1("res valid", 1'b1, res.valid);
		chk1("flag", ef, flag);
		if (c[0]) chk1("lo ninth", el[8], res.lo_b8);
		if (c[1]) chk("lo", {24'h0, el[7:0]}, {24'h0, res.lo});
		if (c[2]) chk1("hi ninth", eh[8], res.hi_b8);
		if (c[3]) chk("hi", {24'h0, eh[7:0]}, {24'h0, res.hi});
		if (c[4]) chk1("branch", eb, res.branch);
	endtask
	initial
	begin
		#100000;
		failures++;
		end_of_test();
	end
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial
	begin
		repeat (6) @(posedge i_mclk);
		i_rst <= 1'b0;
		rd(ninth_bit_pkg::OFS_SER_CTRL, 32'h0, 1'b0);
		rd(ninth_bit_pkg::OFS_PSW, 32'h0, 1'b0);
		rd(ninth_bit_pkg::OFS_WAIT_CNT, 32'h0, 1'b0);
		rd(12'h00c, 32'h0, 1'b1);
		wr(ninth_bit_pkg::OFS_SER_CTRL, 32'h10);
		rd(ninth_bit_pkg::OFS_SER_CTRL, 32'h10, 1'b0);
		chk1("cont_en", 1'b1, cont_en);
		$display("test registers done");
		go <= 1'b1;
		wait_bytes(8'd4);
		gap <= 4'h6;
		wait_bytes(8'd7);
		go <= 1'b0;
		repeat (10) @(posedge i_mclk);
		chk("stall count", 32'd7, stalls);
		rd(ninth_bit_pkg::OFS_WAIT_CNT, 32'd7, 1'b0);
		for (int k = 0; k < 3; k++)
		begin
			if (k == 2) wr(ninth_bit_pkg::OFS_SER_CTRL, 32'h0);
			halt <= (k == 0);
			hold <= (k == 1);
			go <= 1'b1;
			repeat (20) @(posedge i_mclk);
			chk("blocked stalls", 7 + k, stalls);
			go <= 1'b0;
			halt <= 1'b0;
			hold <= 1'b0;
			if (k == 2) wr(ninth_bit_pkg::OFS_SER_CTRL, 32'h10);
			wait_bytes(8'd8 + 8'(k));
		end
		// Offer instructions straight through stall cycles
		gap <= 4'h0;
		go <= 1'b1;
		op_valid <= 1'b1;
		op <= ninth_bit_pkg::OP_NONE;
		wait_bytes(8'd13);
		go <= 1'b0;
		op_valid <= 1'b0;
		repeat (5) @(posedge i_mclk);
		rd(ninth_bit_pkg::OFS_WAIT_CNT, 32'd14, 1'b0);
		wr(ninth_bit_pkg::OFS_WAIT_CNT, 32'h0);
		rd(ninth_bit_pkg::OFS_WAIT_CNT, 32'h0, 1'b0);
		wr(ninth_bit_pkg::OFS_SER_CTRL, 32'h0);
		$display("test wait stall done");
		t_op(0, ninth_bit_pkg::OP_INC, 9'h0ff, 0, 0, 9'h100, 0, 1, 0, 5'h03);
		t_op(1, ninth_bit_pkg::OP_DEC, 9'h100, 0, 0, 9'h0ff, 0, 0, 0, 5'h03);
		t_op(0, ninth_bit_pkg::OP_DECREMENT_BRANCH_NONZERO, 9'h101, 0, 0, 9'h100, 0, 1, 0, 5'h13);
		t_op(1, ninth_bit_pkg::OP_DBZ, 9'h101, 0, 0, 9'h100, 0, 1, 1, 5'h13);
		t_op(0, ninth_bit_pkg::OP_WORD_INCREMENT, 9'h0ff, 9'h0ff, 0, 9'h100, 9'h100, 1, 0, 5'h0f);
		t_op(1, ninth_bit_pkg::OP_WORD_DECREMENT, 9'h000, 9'h100, 0, 9'h0ff, 9'h0ff, 0, 0, 5'h0f);
		t_op(0, ninth_bit_pkg::OP_LOAD, 9'h100, 0, 0, 0, 0, 1, 0, 5'h00);
		t_op(1, ninth_bit_pkg::OP_LOADW, 9'h100, 9'h000, 0, 0, 0, 0, 0, 5'h00);
		t_op(0, ninth_bit_pkg::OP_LOAD, 9'h000, 0, 2'b10, 0, 0, 1, 0, 5'h00);
		t_op(1, ninth_bit_pkg::OP_STORE, 9'h000, 0, 0, 9'h100, 0, 1, 0, 5'h01);
		t_op(0, ninth_bit_pkg::OP_MOV, 9'h100, 0, 0, 9'h000, 0, 0, 0, 5'h01);
		t_op(1, ninth_bit_pkg::OP_PUSH_IMM, 9'h000, 0, 0, 9'h100, 0, 1, 0, 5'h01);
		t_op(0, ninth_bit_pkg::OP_WIDE_MULDIV, 0, 0, 0, 9'h100, 9'h100, 0, 0, 5'h05);
		t_op(0, ninth_bit_pkg::OP_POP, 9'h002, 0, 2'b01, 0, 0, 1, 0, 5'h00);
		t_op(1, ninth_bit_pkg::OP_POP_P, 9'h100, 0, 2'b01, 0, 0, 0, 0, 5'h00);
		t_op(0, ninth_bit_pkg::OP_WORD_POP, 0, 9'h002, 2'b01, 0, 0, 1, 0, 5'h00);
		t_op(1, ninth_bit_pkg::OP_BITOP, 9'h000, 0, 0, 9'h000, 0, 1, 0, 5'h01);
		t_op(1, ninth_bit_pkg::OP_STOREW, 9'h000, 9'h000, 0, 9'h100, 9'h100, 1, 0, 5'h05);
		t_op(0, ninth_bit_pkg::OP_PUSH, 9'h100, 0, 0, 9'h100, 0, 1, 0, 5'h01);
		t_op(1, ninth_bit_pkg::OP_PUSHW, 9'h100, 9'h000, 0, 9'h100, 9'h000, 0, 0, 5'h05);
		t_op(0, ninth_bit_pkg::OP_PUSH_P, 9'h100, 0, 0, 9'h000, 0, 0, 0, 5'h01);
		t_op(1, ninth_bit_pkg::OP_PUSH_BA, 9'h000, 9'h000, 0, 9'h100, 9'h100, 1, 0, 5'h05);
		t_op(1, ninth_bit_pkg::OP_POP, 9'h002, 0, 0, 0, 0, 0, 0, 5'h00);
		t_op(0, ninth_bit_pkg::OP_POP_BA, 9'h000, 9'h100, 0, 0, 0, 1, 0, 5'h00);
		t_op(1, ninth_bit_pkg::OP_WORD_POP, 0, 9'h002, 0, 0, 0, 0, 0, 5'h00);
		t_op(1, ninth_bit_pkg::OP_XCH, 9'h000, 0, 0, 9'h100, 0, 0, 0, 5'h01);
		t_op(0, ninth_bit_pkg::OP_XCHW, 9'h100, 9'h100, 0, 9'h000, 9'h000, 1, 0, 5'h05);
		$display("test ninth bit done");
		end_of_test();
	end
endmodule // tb_top
`default_nettype wire
